// ---- design/mitir_core.sv ----
// Purpose: Instruction timing and interrupt entry/return sequencer.
// Assumes: Fetch holds a decoded instruction until it is taken.
// Notes: Instructions and interrupts are taken on cycle boundaries only.
// Operation
// RULE_01: A set request flag stays set until serviced or cleared.
// RULE_02: A source whose enable is low is never serviced.
// RULE_03: Sleep or idle ends on any request flag rising.
// RULE_04: Software pre-sets a flag to keep it from waking the core.
// RULE_05: Interrupt entry pushes only the program counter.
// RULE_06: Service routines save accumulator and status themselves.
// RULE_07: Interrupt exit pops the return address and sets the gate.
// RULE_08: Subroutine exit pops the return address and leaves the gate.
// RULE_09: Software avoids subroutine invokes inside service routines.
// RULE_10: One instruction cycle is four system clocks.
// RULE_11: Branch, invoke, exits and table read take two cycles.
// RULE_12: Writing the program counter low byte costs an extra cycle.
// RULE_13: A taken skip costs an extra cycle and bypasses one instruction.
// RULE_14: Subroutine exit resumes right after the invoking instruction.
// RULE_15: Bit force high/low changes one bit and keeps the others.
// RULE_16: Logical operations raise the zero flag on a zero result.
// RULE_17: Servicing clears the gate; new requests are still recorded.
// RULE_18: No interrupt is acknowledged while the stack is full.
// RULE_19: Servicing clears the flag, loads the vector, pushes the pc.
// RULE_20: Interrupts are accepted only at instruction cycle boundaries.
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module mitir_core
#(
   parameter int STACK_DEPTH = 4
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Decoded instruction from fetch
   input wire mitir_pkg::mitir_instr_t i_instr,
   output logic o_instr_take,
   // Interrupt source events, one-cycle pulses
   input wire logic [mitir_pkg::NSRC-1:0] i_irq_evt,
   // Register port
   input wire logic [1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // Core state
   output logic [mitir_pkg::PC_W-1:0] o_pc,
   output logic o_zero,
   output logic [7:0] o_result,
   output mitir_pkg::mitir_wb_t o_wb,
   output logic o_sleeping,
   output logic o_irq_enter
);
   localparam int SPW = $clog2(STACK_DEPTH + 1);
   localparam int AW = $clog2(STACK_DEPTH);
   localparam int PCW = mitir_pkg::PC_W;
   localparam int NS = mitir_pkg::NSRC;

   mitir_pkg::mitir_state_t state_r;
   logic [1:0] phase_r;
   logic [PCW-1:0] pc_r;
   logic [SPW-1:0] sp_r;
   logic gate_r;
   logic [NS-1:0] en_r;
   logic [NS-1:0] flag_r;
   logic [NS-1:0] flag_prev_r;
   logic [PCW-1:0] stk_rdata;
   logic boundary;
   logic full;
   logic [NS-1:0] req;
   logic accept;
   logic take;
   logic [0:0] sel;
   logic push;
   logic pop;
   logic pop_ok;
   logic two_cyc;
   logic rise;
   logic ctrl_wr;
   logic [PCW-1:0] pc_inc;
   logic [PCW-1:0] vec;
   logic [7:0] logic_res;
   logic [7:0] bit_mask;
   mitir_pkg::mitir_op_t op;

   // ----------------------------------------------------------------
   // Boundaries and acceptance
   // ----------------------------------------------------------------
   assign op = i_instr.op;
   assign boundary = (phase_r == mitir_pkg::PH_LAST); // [RULE_10]
   assign full = (sp_r == SPW'(STACK_DEPTH));
   // Enables gate service only; flags may sit pending regardless.
   assign req = flag_r & en_r; // [RULE_02]
   // A full stack holds off entry until a pop frees a slot.
   assign accept = boundary && (state_r == mitir_pkg::ST_RUN)
      && gate_r && (|req) && !full; // [RULE_18] [RULE_20]
   assign take = boundary && (state_r == mitir_pkg::ST_RUN)
      && i_instr.valid && !accept;
   assign o_instr_take = take;
   assign sel = req[0] ? 1'b0 : 1'b1;
   assign vec = mitir_pkg::VEC_BASE + PCW'({sel, 2'b00}); // [RULE_19]
   assign pc_inc = pc_r + PCW'(1);
   assign push = accept || (take && op == mitir_pkg::OP_CALL);
   assign pop = take && (op == mitir_pkg::OP_RET
      || op == mitir_pkg::OP_INTERRUPT_EXIT);
   assign pop_ok = pop && (sp_r != '0);
   assign ctrl_wr = i_wr && (i_addr == mitir_pkg::REG_CTRL);
   assign rise = |(flag_r & ~flag_prev_r);
   always_comb
   begin
      case (op)
         mitir_pkg::OP_BRANCH, mitir_pkg::OP_CALL, mitir_pkg::OP_RET,
         mitir_pkg::OP_INTERRUPT_EXIT, mitir_pkg::OP_TBLRD:
            two_cyc = 1'b1; // [RULE_11]
         mitir_pkg::OP_PCLWR:
            two_cyc = 1'b1; // [RULE_12]
         mitir_pkg::OP_SKIP:
            two_cyc = i_instr.skip; // [RULE_13]
         default:
            two_cyc = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Sequencer state and phase
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_r <= mitir_pkg::ST_RUN;
      end
      else
      begin
         case (state_r)
            mitir_pkg::ST_RUN:
               if (accept || (take && two_cyc))
               begin
                  state_r <= mitir_pkg::ST_EXTRA; // [RULE_11]
               end
               else if (take && op == mitir_pkg::OP_SLEEP)
               begin
                  state_r <= mitir_pkg::ST_SLEEP;
               end
            mitir_pkg::ST_EXTRA:
               if (boundary)
               begin
                  state_r <= mitir_pkg::ST_RUN;
               end
            mitir_pkg::ST_SLEEP:
               if (rise)
               begin
                  state_r <= mitir_pkg::ST_RUN; // [RULE_03]
               end
            default:
               state_r <= mitir_pkg::ST_RUN;
         endcase
      end
   end

   // The phase rests at zero in sleep so a wake starts a full cycle.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         phase_r <= 2'h0;
      end
      else if (state_r == mitir_pkg::ST_SLEEP)
      begin
         phase_r <= 2'h0;
      end
      else
      begin
         phase_r <= phase_r + 2'h1; // [RULE_10]
      end
   end

   // ----------------------------------------------------------------
   // Program counter
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         pc_r <= mitir_pkg::PC_RST;
      end
      else if (accept)
      begin
         pc_r <= vec; // [RULE_19]
      end
      else if (take)
      begin
         case (op)
            mitir_pkg::OP_BRANCH, mitir_pkg::OP_CALL:
               pc_r <= i_instr.target;
            mitir_pkg::OP_RET, mitir_pkg::OP_INTERRUPT_EXIT:
               pc_r <= pop_ok ? stk_rdata : pc_inc; // [RULE_14]
            mitir_pkg::OP_PCLWR:
               pc_r <= {pc_r[PCW-1:8], i_instr.data}; // [RULE_12]
            mitir_pkg::OP_SKIP:
               pc_r <= i_instr.skip ? pc_r + PCW'(2) : pc_inc; // [RULE_13]
            default:
               pc_r <= pc_inc;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Return stack
   // ----------------------------------------------------------------
   // Only the program counter is saved; nothing else is stacked.
   // A push into a full stack is dropped, which loses that return.
   mitir_stack #(
      .DEPTH(STACK_DEPTH),
      .W(PCW),
      .AW(AW)
   ) u_stack (
      .i_clk(i_clk),
      .i_we(push && !full), // [RULE_05]
      .i_waddr(AW'(sp_r)),
      .i_wdata(accept ? pc_r : pc_inc), // [RULE_05] [RULE_14]
      .i_raddr(AW'(sp_r - SPW'(1))),
      .o_rdata(stk_rdata)
   );

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         sp_r <= '0;
      end
      else if (push && !full)
      begin
         sp_r <= sp_r + SPW'(1);
      end
      else if (pop_ok)
      begin
         sp_r <= sp_r - SPW'(1);
      end
   end

   // ----------------------------------------------------------------
   // Global gate, enables and request flags
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         gate_r <= mitir_pkg::CTRL_RST[mitir_pkg::CTRL_GATE];
      end
      else if (accept)
      begin
         gate_r <= 1'b0; // [RULE_17]
      end
      else if (take && op == mitir_pkg::OP_INTERRUPT_EXIT)
      begin
         gate_r <= 1'b1; // [RULE_07]
      end
      else if (ctrl_wr)
      begin
         // Subroutine exit never touches the gate. [RULE_08]
         gate_r <= i_wdata[mitir_pkg::CTRL_GATE];
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         en_r <= mitir_pkg::CTRL_RST[mitir_pkg::CTRL_EN_LSB +: NS];
      end
      else if (ctrl_wr)
      begin
         en_r <= i_wdata[mitir_pkg::CTRL_EN_LSB +: NS];
      end
   end

   // A source event in the same cycle as a clear always wins.
   for (genvar g = 0; g < NS; g++)
   begin : g_flag
      always_ff @(posedge i_clk or posedge i_rst)
      begin
         if (i_rst)
         begin
            flag_r[g] <= mitir_pkg::CTRL_RST[mitir_pkg::CTRL_FLAG_LSB + g];
         end
         else if (i_irq_evt[g])
         begin
            flag_r[g] <= 1'b1; // [RULE_17]
         end
         else if (accept && sel == 1'(g))
         begin
            flag_r[g] <= 1'b0; // [RULE_19]
         end
         else if (ctrl_wr)
         begin
            flag_r[g] <= i_wdata[mitir_pkg::CTRL_FLAG_LSB + g]; // [RULE_01]
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         flag_prev_r <= '0;
      end
      else
      begin
         flag_prev_r <= flag_r;
      end
   end

   // ----------------------------------------------------------------
   // Logic results and bit read-modify-write
   // ----------------------------------------------------------------
   always_comb
   begin
      case (op)
         mitir_pkg::OP_AND: logic_res = i_instr.data & i_instr.opnd;
         mitir_pkg::OP_OR: logic_res = i_instr.data | i_instr.opnd;
         mitir_pkg::OP_XOR: logic_res = i_instr.data ^ i_instr.opnd;
         default: logic_res = ~i_instr.data;
      endcase
   end
   assign bit_mask = 8'h01 << i_instr.bit_sel;

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_zero <= 1'b0;
         o_result <= 8'h00;
      end
      else if (take && op >= mitir_pkg::OP_AND && op <= mitir_pkg::OP_CPL)
      begin
         o_result <= logic_res;
         o_zero <= (logic_res == 8'h00); // [RULE_16]
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_wb <= '0;
      end
      else
      begin
         o_wb.valid <= take && (op == mitir_pkg::OP_BSET
            || op == mitir_pkg::OP_BCLR);
         o_wb.data <= (op == mitir_pkg::OP_BSET)
            ? (i_instr.data | bit_mask)
            : (i_instr.data & ~bit_mask); // [RULE_15]
      end
   end

   // ----------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_rdata <= 8'h00;
      end
      else if (i_rd)
      begin
         case (i_addr)
            mitir_pkg::REG_CTRL:
               o_rdata <= 8'({flag_r, 1'b0, en_r, gate_r});
            mitir_pkg::REG_STAT:
               o_rdata <= {o_sleeping, full,
                  state_r == mitir_pkg::ST_EXTRA, 5'(sp_r)};
            mitir_pkg::REG_PCLO:
               o_rdata <= pc_r[7:0];
            default:
               o_rdata <= 8'h00;
         endcase
      end
      else
      begin
         o_rdata <= 8'h00;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_irq_enter <= 1'b0;
      end
      else
      begin
         o_irq_enter <= accept;
      end
   end

   assign o_pc = pc_r;
   assign o_sleeping = (state_r == mitir_pkg::ST_SLEEP);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   flag_hold_a: assert property (flag_r[0] && !(accept && sel == 1'b0)
      && !ctrl_wr |=> flag_r[0]) // [RULE_01]
      else $error("request flag dropped without a clear");
   svc_enable_a: assert property (accept |-> en_r[sel]) // [RULE_02]
      else $error("disabled source was serviced");
   wake_a: assert property (o_sleeping && rise |=> !o_sleeping) // [RULE_03]
      else $error("no wake on rising request flag");
   push_pc_a: assert property (accept |=> sp_r == $past(sp_r) + SPW'(1)
      ##1 stk_rdata == $past(pc_r, 2)) // [RULE_05]
      else $error("entry did not stack the program counter");
   interrupt_exit_gate_a: assert property (take && op == mitir_pkg::OP_INTERRUPT_EXIT
      |=> gate_r) // [RULE_07]
      else $error("interrupt exit left the gate low");
   ret_gate_a: assert property (take && op == mitir_pkg::OP_RET
      && !gate_r && !ctrl_wr |=> !gate_r) // [RULE_08]
      else $error("subroutine exit changed the gate");
   instr_len_a: assert property (take |=> !take [*3]) // [RULE_10]
      else $error("instruction cycle shorter than four clocks");
   two_cyc_a: assert property (take && two_cyc
      |=> (state_r == mitir_pkg::ST_EXTRA) [*4]
      ##1 state_r != mitir_pkg::ST_EXTRA) // [RULE_11]
      else $error("second instruction cycle not four clocks");
   ret_pc_a: assert property (take && op == mitir_pkg::OP_RET && pop_ok
      |=> pc_r == $past(stk_rdata)) // [RULE_14]
      else $error("return did not resume at the stacked address");
   bit_rmw_a: assert property (take && op == mitir_pkg::OP_BCLR
      |=> o_wb.valid && o_wb.data == ($past(i_instr.data)
      & ~$past(bit_mask))) // [RULE_15]
      else $error("bit force low altered other bits");
   // A new event on the serviced source in the entry cycle wins the flag.
   entry_a: assert property (accept |=> !gate_r && pc_r == $past(vec)
      && (!flag_r[$past(sel)] || $past(i_irq_evt[sel]))) // [RULE_19]
      else $error("entry did not vector, clear gate and flag");
   full_block_a: assert property (full |-> !accept) // [RULE_18]
      else $error("interrupt taken with full stack");
   bound_a: assert property (accept |-> phase_r == mitir_pkg::PH_LAST
      && state_r == mitir_pkg::ST_RUN) // [RULE_20]
      else $error("interrupt accepted off a boundary");

   entry_c: cover property (accept ##[1:40] take && op == mitir_pkg::OP_INTERRUPT_EXIT);
   wake_c: cover property (o_sleeping ##1 !o_sleeping);
   skip_c: cover property (take && op == mitir_pkg::OP_SKIP && i_instr.skip);
endmodule // mitir_core

// ---- design/mitir_pkg.sv ----
// Purpose: Shared constants and types for the instruction sequencer.
// Assumes: One system clock; decoded instructions arrive from fetch.
// Notes: Register offsets are word indices on the plain register port.
package mitir_pkg;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int INSTR_CLKS = 4;
   localparam logic [1:0] PH_LAST = 2'(INSTR_CLKS - 1);
   // -----------------------------------------------------------------
   // Sizes and reset values
   // -----------------------------------------------------------------
   localparam int NSRC = 2;
   localparam int PC_W = 11;
   localparam logic [PC_W-1:0] PC_RST = 11'h000;
   localparam logic [PC_W-1:0] VEC_BASE = 11'h004;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // -----------------------------------------------------------------
   // Register map and fields
   // -----------------------------------------------------------------
   localparam logic [1:0] REG_CTRL = 2'h0;
   localparam logic [1:0] REG_STAT = 2'h1;
   localparam logic [1:0] REG_PCLO = 2'h2;
   localparam int CTRL_GATE = 0;
   localparam int CTRL_EN_LSB = 1;
   localparam int CTRL_FLAG_LSB = 4;
   localparam int STAT_SP_LSB = 0;
   localparam int STAT_EXTRA = 5;
   localparam int STAT_FULL = 6;
   localparam int STAT_SLEEP = 7;
   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_PLAIN = 4'h0, OP_BRANCH = 4'h1, OP_CALL = 4'h2, OP_RET = 4'h3,
      OP_INTERRUPT_EXIT = 4'h4, OP_TBLRD = 4'h5, OP_PCLWR = 4'h6, OP_SKIP = 4'h7,
      OP_BSET = 4'h8, OP_BCLR = 4'h9, OP_AND = 4'ha, OP_OR = 4'hb,
      OP_XOR = 4'hc, OP_CPL = 4'hd, OP_SLEEP = 4'he
   } mitir_op_t;
   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_EXTRA = 3'b010,
      ST_SLEEP = 3'b100
   } mitir_state_t;
   typedef struct packed {
      logic valid;
      mitir_op_t op;
      logic [PC_W-1:0] target;
      logic [7:0] data;
      logic [7:0] opnd;
      logic [2:0] bit_sel;
      logic skip;
   } mitir_instr_t;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } mitir_wb_t;
endpackage

// ---- design/mitir_stack.sv ----
// Purpose: Return-address stack storage with registered read data.
// Assumes: Single clock; one write and one read address per cycle.
// Notes: Read data lag the read address by one clock.
`timescale 1ns/1ps
module mitir_stack
#(
   parameter int DEPTH = 4,
   parameter int W = 11,
   parameter int AW = 2
)
(
   // Clock
   input wire logic i_clk,
   // Write side
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [W-1:0] i_wdata,
   // Read side
   input wire logic [AW-1:0] i_raddr,
   output logic [W-1:0] o_rdata
);
   logic [W-1:0] mem [DEPTH];

   always_ff @(posedge i_clk)
   begin
      if (i_we)
      begin
         mem[i_waddr] <= i_wdata;
      end
   end

   always_ff @(posedge i_clk)
   begin
      o_rdata <= mem[i_raddr];
   end
endmodule // mitir_stack

// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench for the instruction sequencer.
// Assumes: The bench plays fetch, interrupt sources and software.
// Notes: Stack depth is cut to two so that a full stack comes quickly.
`timescale 1ns/1ps
module tb_top;
   // ------------------------------------------------------------------
   // Signals and bookkeeping
   // ------------------------------------------------------------------
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   mitir_pkg::mitir_instr_t i_instr = '0;
   logic [1:0] i_irq_evt = 2'h0;
   logic [1:0] i_addr = 2'h0;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic o_instr_take;
   logic [7:0] o_rdata;
   logic [10:0] o_pc;
   logic o_zero;
   logic [7:0] o_result;
   mitir_pkg::mitir_wb_t o_wb;
   logic o_sleeping;
   logic o_irq_enter;
   logic [31:0] q_take[$];
   logic [31:0] q_wb[$];
   logic [31:0] q_rd[$];
   logic [31:0] q_irq[$];
   logic [10:0] stk[$];
   logic [10:0] pc_m = 11'h000;
   logic [7:0] res_m = 8'h00;
   logic zero_m = 1'b0;
   logic prev_dbl = 1'b0;
   logic tk = 1'b0;
   logic rd_q = 1'b0;
   int mismatches = 0;
   int samples_checked = 0;

   always #20 i_clk = ~i_clk;

   mitir_core #(.STACK_DEPTH(2)) mitir_core_inst (
      .i_clk(i_clk), .i_rst(i_rst), .i_instr(i_instr),
      .o_instr_take(o_instr_take), .i_irq_evt(i_irq_evt),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .o_pc(o_pc), .o_zero(o_zero),
      .o_result(o_result), .o_wb(o_wb), .o_sleeping(o_sleeping),
      .o_irq_enter(o_irq_enter));

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("mismatches=%0d samples_checked=%0d", mismatches,
         samples_checked);
      if (mismatches == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   function automatic mitir_pkg::mitir_instr_t mk(
      input mitir_pkg::mitir_op_t op, input logic sk);
      mitir_pkg::mitir_instr_t t;
      t = {1'b1, op, 11'($urandom), 8'($urandom), 8'($urandom),
         3'($urandom), sk};
      return t;
   endfunction

   // Notes the expected outcome, then holds the instruction until taken.
   task automatic exec(input mitir_pkg::mitir_instr_t t, input logic chk);
      logic [10:0] nx;
      logic dbl;
      int n;
      nx = pc_m + 11'h1;
      dbl = (t.op inside {mitir_pkg::OP_BRANCH, mitir_pkg::OP_CALL,
         mitir_pkg::OP_RET, mitir_pkg::OP_INTERRUPT_EXIT, mitir_pkg::OP_TBLRD,
         mitir_pkg::OP_PCLWR}) || (t.op == mitir_pkg::OP_SKIP && t.skip);
      case (t.op)
         mitir_pkg::OP_BRANCH: nx = t.target;
         mitir_pkg::OP_CALL:
         begin
            stk.push_back(nx);
            nx = t.target;
         end
         mitir_pkg::OP_RET, mitir_pkg::OP_INTERRUPT_EXIT: nx = stk.pop_back();
         mitir_pkg::OP_PCLWR: nx = {pc_m[10:8], t.data};
         mitir_pkg::OP_SKIP: nx = t.skip ? pc_m + 11'h2 : nx;
         mitir_pkg::OP_BSET: q_wb.push_back({24'h0,
            t.data | (8'h1 << t.bit_sel)});
         mitir_pkg::OP_BCLR: q_wb.push_back({24'h0,
            t.data & ~(8'h1 << t.bit_sel)});
         mitir_pkg::OP_AND: res_m = t.data & t.opnd;
         mitir_pkg::OP_OR: res_m = t.data | t.opnd;
         mitir_pkg::OP_XOR: res_m = t.data ^ t.opnd;
         mitir_pkg::OP_CPL: res_m = ~t.data;
         default: ;
      endcase
      if (t.op >= mitir_pkg::OP_AND && t.op <= mitir_pkg::OP_CPL)
         zero_m = (res_m == 8'h00);
      pc_m = nx;
      q_take.push_back({12'h0, zero_m, res_m, pc_m});
      i_instr <= t;
      n = 0;
      do
      begin
         @(negedge i_clk);
         n++;
      end
      while (o_instr_take !== 1'b1 && n < 40);
      @(posedge i_clk);
      if (chk)
         cmp(n, prev_dbl ? 8 : 4);
      prev_dbl = dbl;
   endtask

   // A read notes its expected data; a gap cycle follows every strobe.
   task automatic bus(input logic w, input logic [1:0] a,
      input logic [7:0] d);
      i_wr <= w;
      i_rd <= ~w;
      i_addr <= a;
      i_wdata <= d;
      if (!w)
         q_rd.push_back({24'h0, d});
      @(posedge i_clk);
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      @(posedge i_clk);
   endtask

   task automatic pulse(input int s);
      i_irq_evt <= 2'(1 << s);
      @(posedge i_clk);
      i_irq_evt <= 2'h0;
      @(posedge i_clk);
   endtask

   task automatic idle(input int n);
      i_instr <= '0;
      repeat (n) @(posedge i_clk);
   endtask

   task automatic expect_irq(input int s);
      stk.push_back(pc_m);
      pc_m = mitir_pkg::VEC_BASE + 11'(4 * s);
      q_irq.push_back({21'h0, pc_m});
   endtask

   task automatic drain();
      for (int k = 0; k < 24 && q_irq.size() != 0; k++)
         @(posedge i_clk);
      cmp(q_irq.size(), 0);
   endtask

   // ------------------------------------------------------------------
   // Monitor: results are matched against the oldest note
   // ------------------------------------------------------------------
   always @(posedge i_clk)
      rd_q <= i_rd;

   always @(negedge i_clk)
   begin
      if (!i_rst)
      begin
         if (tk)
            cmp({o_zero, o_result, o_pc},
               q_take.size() ? q_take.pop_front() : 'x);
         if (o_wb.valid === 1'b1)
            cmp(o_wb.data, q_wb.size() ? q_wb.pop_front() : 'x);
         if (rd_q)
            cmp(o_rdata, q_rd.size() ? q_rd.pop_front() : 'x);
         if (o_irq_enter === 1'b1)
            cmp(o_pc, q_irq.size() ? q_irq.pop_front() : 'x);
         tk = (o_instr_take === 1'b1);
      end
   end

   initial
   begin
      #(40 * 5000);
      mismatches++;
      report_and_stop();
   end

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   initial
   begin
      mitir_pkg::mitir_instr_t t;
      void'($urandom(32'h9710));
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
      bus(0, 2'h0, 8'h00);
      bus(1, 2'h3, 8'hff);
      bus(0, 2'h3, 8'h00);
      bus(1, 2'h1, 8'hff);
      bus(0, 2'h1, 8'h00);
      bus(1, 2'h0, 8'h36);
      idle(16);
      bus(0, 2'h0, 8'h36);
      bus(1, 2'h0, 8'h00);
      // Every class but interrupt exit and sleep back to back; a bad cycle count breaks the chain.
      for (int k = 0; k < 28; k++)
         if (k / 2 != 4)
            exec(mk(mitir_pkg::mitir_op_t'(4'(k / 2)), k[0]), k > 0);
      t = mk(mitir_pkg::OP_XOR, 1'b0);
      t.opnd = t.data;
      exec(t, 1'b1);
      idle(8);
      bus(0, 2'h2, pc_m[7:0]);
      bus(0, 2'h1, 8'h00);
      // Enable, gate, the second source's vector and the two kinds of return.
      bus(1, 2'h0, 8'h03);
      pulse(1);
      idle(16);
      bus(0, 2'h0, 8'h23);
      expect_irq(0);
      pulse(0);
      drain();
      idle(8);
      bus(0, 2'h0, 8'h22);
      bus(0, 2'h1, 8'h01);
      pulse(0);
      idle(16);
      bus(0, 2'h0, 8'h32);
      // The routine alters no result or flag, so nothing needs saving.
      exec(mk(mitir_pkg::OP_INTERRUPT_EXIT, 1'b0), 1'b0);
      expect_irq(0);
      exec(mk(mitir_pkg::OP_RET, 1'b0), 1'b0);
      idle(8);
      bus(0, 2'h0, 8'h22);
      expect_irq(1);
      bus(1, 2'h0, 8'h25);
      drain();
      exec(mk(mitir_pkg::OP_INTERRUPT_EXIT, 1'b0), 1'b0);
      idle(8);
      bus(0, 2'h0, 8'h05);
      // Full stack holds off an enabled request until a pop.
      bus(1, 2'h0, 8'h02);
      exec(mk(mitir_pkg::OP_CALL, 1'b0), 1'b0);
      exec(mk(mitir_pkg::OP_CALL, 1'b0), 1'b1);
      idle(16);
      bus(0, 2'h1, 8'h42);
      bus(1, 2'h0, 8'h03);
      pulse(0);
      idle(16);
      bus(0, 2'h0, 8'h13);
      exec(mk(mitir_pkg::OP_RET, 1'b0), 1'b0);
      expect_irq(0);
      // No invoke inside the routine: the stack is full.
      exec(mk(mitir_pkg::OP_INTERRUPT_EXIT, 1'b0), 1'b0);
      exec(mk(mitir_pkg::OP_RET, 1'b0), 1'b1);
      idle(8);
      bus(0, 2'h1, 8'h00);
      bus(0, 2'h0, 8'h03);
      // A flag already high cannot wake the core; a rising one does.
      bus(1, 2'h0, 8'h20);
      exec(mk(mitir_pkg::OP_SLEEP, 1'b0), 1'b0);
      idle(8);
      bus(0, 2'h1, 8'h80);
      pulse(1);
      idle(8);
      @(negedge i_clk);
      cmp(o_sleeping, 1);
      @(posedge i_clk);
      pulse(0);
      idle(8);
      @(negedge i_clk);
      cmp(o_sleeping, 0);
      @(posedge i_clk);
      bus(0, 2'h1, 8'h00);
      bus(0, 2'h0, 8'h30);
      exec(mk(mitir_pkg::OP_PLAIN, 1'b0), 1'b0);
      idle(8);
      cmp(q_take.size() + q_wb.size() + q_rd.size() + q_irq.size(), 0);
      report_and_stop();
   end
endmodule // tb_top
